//--- crdma_ep_mem.sv
// endpoint memory: one write port, one registered read port
module crdma_ep_mem
  import crdma_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [CRDMA_MEM_AW-1:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [CRDMA_MEM_AW-1:0] raddr,
  output logic [31:0] rdata
);
  // storage has no reset; contents are only defined once written
  logic [31:0] mem [CRDMA_MEM_DEPTH];

  // write and registered read, both frozen by the clock enable
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule : crdma_ep_mem

//--- crdma_host_model.sv
// host memory and interrupt sink on the far side of the read channel
module crdma_host_model
  import crdma_pkg::*;
(
  input wire logic clk,
  input wire logic mst_req,
  input wire logic mst_write,
  input wire logic [63:0] mst_addr,
  input wire logic [31:0] mst_wdata,
  output logic mst_gnt,
  output logic cpl_valid,
  output logic [31:0] cpl_data,
  input wire logic msi_req,
  output logic msi_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [logic [63:0]]; // host memory, filled before the header
  logic [31:0] wr_q [$]; // data of each write taken
  logic [63:0] wa_q [$]; // address of each write taken
  logic [63:0] rd_addr; // address of the read owed
  int lat = 0; // stall cycles before grant and before completion
  int n_msi = 0; // interrupts taken, the host's completion sign
  int stall = 0;
  int pend = -1; // cycles to the completion, -1 when none is owed
  initial begin
    mst_gnt = 1'b0;
    cpl_valid = 1'b0;
    cpl_data = 32'h0000_0000;
    msi_ack = 1'b0;
  end
  // answer on the falling edge so the engine samples settled values
  always @(negedge clk) begin
    mst_gnt <= 1'b0;
    cpl_valid <= 1'b0;
    msi_ack <= msi_req && !msi_ack;
    cpl_data <= ~cpl_data; // stale data flips every cycle between completions
    if (msi_req && !msi_ack)
      n_msi++;
    if (pend > 0)
      pend--;
    if (pend == 0) begin
      // unwritten places answer with a pattern, not a lucky zero
      cpl_data <= mem.exists(rd_addr) ? mem[rd_addr] : ~rd_addr[31:0];
      cpl_valid <= 1'b1;
      pend = -1;
    end else if (mst_req && pend < 0 && !mst_gnt) begin
      if (stall < lat) begin
        stall++;
      end else begin
        stall = 0;
        mst_gnt <= 1'b1;
        if (mst_write) begin
          mem[mst_addr] = mst_wdata; // count and done flag land here
          wr_q.push_back(mst_wdata);
          wa_q.push_back(mst_addr);
        end else begin
          rd_addr = mst_addr;
          pend = 1 + lat; // a single read in flight
        end
      end
    end
  end
endmodule : crdma_host_model

//--- crdma_pkg.sv
// constants, states and carrier types of the chaining dma read channel
package crdma_pkg;
  // control window two offsets (byte addresses)
  localparam logic [7:0] CRDMA_OFF_COUNT_CTRL = 8'h00;
  localparam logic [7:0] CRDMA_OFF_TAB_HI = 8'h14;
  localparam logic [7:0] CRDMA_OFF_TAB_LO = 8'h18;
  localparam logic [7:0] CRDMA_OFF_LAST_IDX = 8'h1c;
  localparam logic [7:0] CRDMA_OFF_STATUS = 8'h20;
  // descriptor layout in host memory
  localparam logic [63:0] CRDMA_DESC_FIRST_OFS = 64'h0000_0000_0000_0010;
  localparam int CRDMA_DESC_STRIDE_SHIFT = 4;
  localparam logic [63:0] CRDMA_COUNT_OFS = 64'h0000_0000_0000_000c;
  localparam logic [1:0] CRDMA_DESC_LAST_WORD = 2'h3;
  // descriptor control bits in the first dword
  localparam int CRDMA_LEN_MSB = 15;
  localparam int CRDMA_CTRL_MSI_BIT = 16;
  localparam int CRDMA_CTRL_FLAG_BIT = 17;
  // completion status word: bit 16 is endpoint_done_flag, low half the count
  localparam int CRDMA_STAT_FLAG_BIT = 16;
  // reset values
  localparam logic [31:0] CRDMA_REG_RST = 32'h0000_0000;
  localparam logic [15:0] CRDMA_CNT_RST = 16'h0000;
  // endpoint memory
  localparam int CRDMA_MEM_AW = 10;
  localparam int CRDMA_MEM_DEPTH = 1024;

  // engine states
  typedef enum logic [2:0] {
    CRDMA_IDLE = 3'b000,
    CRDMA_FETCH = 3'b001,
    CRDMA_FETCH_WAIT = 3'b010,
    CRDMA_XFER = 3'b011,
    CRDMA_XFER_WAIT = 3'b100,
    CRDMA_STATUS = 3'b101,
    CRDMA_MSI = 3'b110
  } crdma_state_t;

  // all engine state in one carrier
  typedef struct packed {
    crdma_state_t state;
    logic [31:0] hdr_ctrl;
    logic [31:0] tab_hi;
    logic [31:0] tab_lo;
    logic [31:0] last_idx;
    logic [15:0] idx;
    logic [1:0] word;
    logic [31:0] desc_dw0;
    logic [31:0] ep_addr;
    logic [31:0] src_hi;
    logic [31:0] src_lo;
    logic [15:0] xfer;
    logic [15:0] done_cnt;
  } crdma_regs_t;
endpackage : crdma_pkg

//--- crdma_read_channel.sv
// chaining dma read channel: header registers, descriptor walk, data copy
// What this block does
// - descriptors are four dwords at 16-byte stride
// - header registers at 0x0, 0x14, 0x18, 0x1c
// - start only after last-index dword is written
// - copy length dwords host source to endpoint
// - write completed count at table base plus 0xc
// - msi after final descriptor when control requests
// - done flag written for first and last descriptors
module crdma_read_channel
  import crdma_pkg::*;
(
  input wire logic clk, // 200 MHz
  input wire logic nrst, // asynchronous, active low
  input wire logic ce, // freezes all state while low
  // control window two target port
  input wire logic tgt_wr,
  input wire logic tgt_rd,
  input wire logic [7:0] tgt_addr,
  input wire logic [31:0] tgt_wdata,
  output logic [31:0] tgt_rdata,
  output logic tgt_rvalid,
  // host memory master port, one dword per request
  output logic mst_req,
  output logic mst_write,
  output logic [63:0] mst_addr,
  output logic [31:0] mst_wdata,
  input wire logic mst_gnt,
  input wire logic cpl_valid,
  input wire logic [31:0] cpl_data,
  // message signalled interrupt request
  output logic msi_req,
  input wire logic msi_ack,
  // endpoint memory read port for local logic
  input wire logic [CRDMA_MEM_AW-1:0] ep_raddr,
  output logic [31:0] ep_rdata,
  output logic busy
);
  crdma_regs_t r; // registered engine state
  crdma_regs_t next_r; // next engine state
  logic [31:0] next_tgt_rdata; // read answer data
  logic next_tgt_rvalid; // read answer strobe
  logic mem_we; // endpoint memory write strobe
  logic [63:0] tab_base; // descriptor table base in host memory
  logic [63:0] desc_base; // current descriptor address
  logic [63:0] src_base; // current data source address
  logic is_last; // current descriptor is the final one
  logic want_flag; // status word carries the done flag
  logic [31:0] status_word; // word written back to host memory

  assign tab_base = {r.tab_hi, r.tab_lo};
  // descriptor n sits at base + 0x10 + 16*n
  assign desc_base = tab_base + CRDMA_DESC_FIRST_OFS
    + ({48'h0, r.idx} << CRDMA_DESC_STRIDE_SHIFT);
  assign src_base = {r.src_hi, r.src_lo};
  assign is_last = (r.idx == r.last_idx[15:0]);
  assign want_flag = r.desc_dw0[CRDMA_CTRL_FLAG_BIT]
    && ((r.idx == CRDMA_CNT_RST) || is_last);
  assign status_word = {15'h0000, want_flag, 16'(r.done_cnt + 16'h0001)};

  // master port is a pure function of the state registers
  always_comb begin
    mst_req = 1'b0;
    mst_write = 1'b0;
    mst_addr = 64'h0;
    mst_wdata = 32'h0;
    case (r.state)
      CRDMA_FETCH: begin
        mst_req = 1'b1;
        mst_addr = desc_base + {60'h0, r.word, 2'b00};
      end
      CRDMA_XFER: begin
        mst_req = 1'b1;
        mst_addr = src_base + {46'h0, r.xfer, 2'b00};
      end
      CRDMA_STATUS: begin
        mst_req = 1'b1;
        mst_write = 1'b1;
        mst_addr = tab_base + CRDMA_COUNT_OFS;
        mst_wdata = status_word;
      end
      default: begin
        mst_req = 1'b0;
      end
    endcase
  end

  assign msi_req = (r.state == CRDMA_MSI);
  assign busy = (r.state != CRDMA_IDLE);
  // completions land in endpoint memory only while a data read is open
  assign mem_we = ce && (r.state == CRDMA_XFER_WAIT) && cpl_valid;

  // next-state logic for registers and the descriptor walk
  always_comb begin
    next_r = r;
    next_tgt_rvalid = tgt_rd;
    next_tgt_rdata = CRDMA_REG_RST;
    // register writes; header may be rewritten while busy but only starts when idle
    if (tgt_wr) begin
      if (tgt_addr == CRDMA_OFF_COUNT_CTRL) begin
        next_r.hdr_ctrl = tgt_wdata;
      end else if (tgt_addr == CRDMA_OFF_TAB_HI) begin
        next_r.tab_hi = tgt_wdata;
      end else if (tgt_addr == CRDMA_OFF_TAB_LO) begin
        next_r.tab_lo = tgt_wdata;
      end else if (tgt_addr == CRDMA_OFF_LAST_IDX) begin
        next_r.last_idx = tgt_wdata;
      end
    end
    // register reads; unmapped offsets answer zero
    if (tgt_addr == CRDMA_OFF_COUNT_CTRL) begin
      next_tgt_rdata = r.hdr_ctrl;
    end else if (tgt_addr == CRDMA_OFF_TAB_HI) begin
      next_tgt_rdata = r.tab_hi;
    end else if (tgt_addr == CRDMA_OFF_TAB_LO) begin
      next_tgt_rdata = r.tab_lo;
    end else if (tgt_addr == CRDMA_OFF_LAST_IDX) begin
      next_tgt_rdata = r.last_idx;
    end else if (tgt_addr == CRDMA_OFF_STATUS) begin
      next_tgt_rdata = {busy, 15'h0000, r.done_cnt};
    end
    case (r.state)
      CRDMA_IDLE: begin
        // the last-index write is the start trigger
        if (tgt_wr && (tgt_addr == CRDMA_OFF_LAST_IDX)) begin
          next_r.state = CRDMA_FETCH;
          next_r.idx = CRDMA_CNT_RST;
          next_r.word = 2'h0;
          next_r.done_cnt = CRDMA_CNT_RST;
        end
      end
      CRDMA_FETCH: begin
        if (mst_gnt) begin
          next_r.state = CRDMA_FETCH_WAIT;
        end
      end
      CRDMA_FETCH_WAIT: begin
        if (cpl_valid) begin
          // dword order: length/control, endpoint, host upper, host lower
          case (r.word)
            2'h0: next_r.desc_dw0 = cpl_data;
            2'h1: next_r.ep_addr = cpl_data;
            2'h2: next_r.src_hi = cpl_data;
            default: next_r.src_lo = cpl_data;
          endcase
          next_r.word = r.word + 2'h1;
          next_r.xfer = CRDMA_CNT_RST;
          if (r.word != CRDMA_DESC_LAST_WORD) begin
            next_r.state = CRDMA_FETCH;
          end else if (r.desc_dw0[CRDMA_LEN_MSB:0] == CRDMA_CNT_RST) begin
            next_r.state = CRDMA_STATUS; // empty descriptor still counts
          end else begin
            next_r.state = CRDMA_XFER;
          end
        end
      end
      CRDMA_XFER: begin
        if (mst_gnt) begin
          next_r.state = CRDMA_XFER_WAIT;
        end
      end
      CRDMA_XFER_WAIT: begin
        if (cpl_valid) begin
          next_r.xfer = r.xfer + 16'h0001;
          if (16'(r.xfer + 16'h0001) == r.desc_dw0[CRDMA_LEN_MSB:0]) begin
            next_r.state = CRDMA_STATUS;
          end else begin
            next_r.state = CRDMA_XFER;
          end
        end
      end
      CRDMA_STATUS: begin
        if (mst_gnt) begin
          next_r.done_cnt = r.done_cnt + 16'h0001;
          next_r.word = 2'h0;
          if (!is_last) begin
            next_r.idx = r.idx + 16'h0001;
            next_r.state = CRDMA_FETCH;
          end else if (r.desc_dw0[CRDMA_CTRL_MSI_BIT]) begin
            next_r.state = CRDMA_MSI;
          end else begin
            next_r.state = CRDMA_IDLE;
          end
        end
      end
      CRDMA_MSI: begin
        if (msi_ack) begin
          next_r.state = CRDMA_IDLE;
        end
      end
      default: begin
        next_r.state = CRDMA_IDLE;
      end
    endcase
  end

  // state registers only; constants under reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{state: CRDMA_IDLE, hdr_ctrl: CRDMA_REG_RST, tab_hi: CRDMA_REG_RST,
        tab_lo: CRDMA_REG_RST, last_idx: CRDMA_REG_RST, idx: CRDMA_CNT_RST, word: 2'h0,
        desc_dw0: CRDMA_REG_RST, ep_addr: CRDMA_REG_RST, src_hi: CRDMA_REG_RST,
        src_lo: CRDMA_REG_RST, xfer: CRDMA_CNT_RST, done_cnt: CRDMA_CNT_RST};
      tgt_rdata <= CRDMA_REG_RST;
      tgt_rvalid <= 1'b0;
    end else if (ce) begin
      r <= next_r;
      tgt_rdata <= next_tgt_rdata;
      tgt_rvalid <= next_tgt_rvalid;
    end
  end

  // endpoint memory, written at endpoint address plus dword index
  crdma_ep_mem u_mem (
    .clk(clk),
    .ce(ce),
    .we(mem_we),
    .waddr(CRDMA_MEM_AW'(r.ep_addr + {16'h0, r.xfer})),
    .wdata(cpl_data),
    .raddr(ep_raddr),
    .rdata(ep_rdata)
  );

  // checks of the walk
  AST_START: assert property (@(posedge clk) disable iff (!nrst)
    (ce && r.state == CRDMA_IDLE && tgt_wr && tgt_addr == CRDMA_OFF_LAST_IDX)
    |=> (r.state == CRDMA_FETCH && r.idx == 16'h0))
    else $error("engine did not start on last-index write");
  AST_NO_START: assert property (@(posedge clk) disable iff (!nrst)
    (ce && r.state == CRDMA_IDLE && !(tgt_wr && tgt_addr == CRDMA_OFF_LAST_IDX))
    |=> r.state == CRDMA_IDLE)
    else $error("engine left idle without trigger");
  AST_DESC_ADDR: assert property (@(posedge clk) disable iff (!nrst)
    (r.state == CRDMA_FETCH) |-> mst_addr == tab_base + 64'h10
      + {44'h0, r.idx, 4'h0} + {60'h0, r.word, 2'b00})
    else $error("descriptor fetch address wrong");
  AST_COUNT_ADDR: assert property (@(posedge clk) disable iff (!nrst)
    (r.state == CRDMA_STATUS) |-> (mst_write && mst_addr == tab_base + 64'hc
      && mst_wdata[15:0] == 16'(r.done_cnt + 16'h1)))
    else $error("count write wrong");
  AST_COUNT_INC: assert property (@(posedge clk) disable iff (!nrst)
    (ce && r.state == CRDMA_STATUS && mst_gnt) |=> r.done_cnt == $past(r.done_cnt) + 16'h1)
    else $error("done count not advanced");
  AST_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    (r.state == CRDMA_STATUS && r.idx != 16'h0 && !is_last) |-> !mst_wdata[16])
    else $error("done flag on a middle descriptor");
  AST_MSI: assert property (@(posedge clk) disable iff (!nrst)
    (ce && r.state == CRDMA_STATUS && mst_gnt && is_last && r.desc_dw0[16]) |=> msi_req)
    else $error("msi not raised after final descriptor");
  AST_WALK: assert property (@(posedge clk) disable iff (!nrst)
    (ce && r.state == CRDMA_STATUS && mst_gnt && !is_last)
    |=> (r.state == CRDMA_FETCH && r.idx == $past(r.idx) + 16'h1))
    else $error("descriptor index did not step");
  AST_LEN: assert property (@(posedge clk) disable iff (!nrst)
    (ce && r.state == CRDMA_XFER_WAIT && cpl_valid && r.xfer + 16'h1 == r.desc_dw0[15:0])
    |=> r.state == CRDMA_STATUS)
    else $error("transfer did not end at length");
  COV_START: cover property (@(posedge clk) disable iff (!nrst) r.state == CRDMA_FETCH);
  COV_DATA: cover property (@(posedge clk) disable iff (!nrst) mem_we);
  COV_MSI: cover property (@(posedge clk) disable iff (!nrst) msi_req && msi_ack);
  COV_MULTI: cover property (@(posedge clk) disable iff (!nrst)
    r.state == CRDMA_STATUS && r.idx == 16'h2);
endmodule : crdma_read_channel

//--- testbench.sv
// self-checking bench of the read channel against the host memory model
module testbench
  import crdma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b0;
  logic tgt_wr = 1'b0;
  logic tgt_rd = 1'b0;
  logic [7:0] tgt_addr = 8'h00;
  logic [31:0] tgt_wdata = 32'h0000_0000;
  logic [CRDMA_MEM_AW-1:0] ep_raddr = '0;
  logic [31:0] tgt_rdata, mst_wdata, cpl_data, ep_rdata;
  logic [63:0] mst_addr;
  logic tgt_rvalid, mst_req, mst_write, mst_gnt, cpl_valid, msi_req, msi_ack, busy;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  crdma_read_channel u_crdma_read_channel (.clk(clk), .nrst(nrst), .ce(ce),
    .tgt_wr(tgt_wr), .tgt_rd(tgt_rd), .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata),
    .tgt_rdata(tgt_rdata), .tgt_rvalid(tgt_rvalid), .mst_req(mst_req),
    .mst_write(mst_write), .mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_gnt(mst_gnt),
    .cpl_valid(cpl_valid), .cpl_data(cpl_data), .msi_req(msi_req), .msi_ack(msi_ack),
    .ep_raddr(ep_raddr), .ep_rdata(ep_rdata), .busy(busy));
  crdma_host_model u_crdma_host_model (.clk(clk), .mst_req(mst_req),
    .mst_write(mst_write), .mst_addr(mst_addr), .mst_wdata(mst_wdata), .mst_gnt(mst_gnt),
    .cpl_valid(cpl_valid), .cpl_data(cpl_data), .msi_req(msi_req), .msi_ack(msi_ack));
  // the one compare: case equality so unknowns never match
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  // window write: one-cycle strobe, driven on the falling edge
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    tgt_wr = 1'b1;
    tgt_addr = a;
    tgt_wdata = d;
    @(negedge clk);
    tgt_wr = 1'b0;
  endtask : reg_wr
  // window read: answer stands from the taking edge, checked half a cycle later
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    tgt_rd = 1'b1;
    tgt_addr = a;
    @(negedge clk);
    tgt_rd = 1'b0;
    check("tgt_rvalid", 64'h1, {63'h0, tgt_rvalid});
    check("tgt_rdata", {32'h0, exp}, {32'h0, tgt_rdata});
    // the answer strobe stands for one cycle only
    @(negedge clk);
    check("tgt_rvalid low", 64'h0, {63'h0, tgt_rvalid});
  endtask : reg_rd
  // endpoint memory word, registered one cycle
  task automatic ep_chk(input int a, input logic [31:0] exp);
    @(negedge clk);
    ep_raddr = a[CRDMA_MEM_AW-1:0];
    @(negedge clk);
    check("ep_rdata", {32'h0, exp}, {32'h0, ep_rdata});
  endtask : ep_chk
  // descriptor plus its incrementing data buffer in host memory
  task automatic put_desc(input logic [63:0] a, input logic [31:0] d0, d1, d2, d3, pat);
    u_crdma_host_model.mem[a] = d0;
    u_crdma_host_model.mem[a + 64'h4] = d1;
    u_crdma_host_model.mem[a + 64'h8] = d2;
    u_crdma_host_model.mem[a + 64'hc] = d3;
    for (int k = 0; k < int'(d0[15:0]); k++)
      u_crdma_host_model.mem[{d2, d3} + 64'(4 * k)] = pat + 32'(k);
  endtask : put_desc
  // bounded wait for the engine to go idle
  task automatic wait_idle();
    for (int i = 0; i < 30000 && busy !== 1'b0; i++)
      @(negedge clk);
    check("busy", 64'h0, {63'h0, busy});
  endtask : wait_idle
  // three-descriptor chain; header written in order, index last
  task automatic t_chain();
    put_desc(64'h910, 32'h0003_0052, 32'h3, 32'h0, 32'h8df0, 32'haaa0_0001);
    put_desc(64'h920, 32'h0003_0400, 32'h0, 32'ha, 32'h1_0900, 32'hbbbb_0001);
    put_desc(64'h930, 32'h0003_0284, 32'h0, 32'h0, 32'h2_0ef0, 32'hcccc_0001);
    reg_wr(CRDMA_OFF_COUNT_CTRL, 32'h3);
    reg_wr(CRDMA_OFF_TAB_HI, 32'h0);
    reg_wr(CRDMA_OFF_TAB_LO, 32'h900);
    repeat (4) @(negedge clk);
    check("busy", 64'h0, {63'h0, busy});
    check("mst_req", 64'h0, {63'h0, mst_req});
    reg_rd(CRDMA_OFF_COUNT_CTRL, 32'h3);
    reg_rd(CRDMA_OFF_TAB_LO, 32'h900);
    reg_rd(8'h40, 32'h0);
    reg_wr(CRDMA_OFF_LAST_IDX, 32'h2);
    check("busy", 64'h1, {63'h0, busy});
    check("mst_addr", 64'h910, mst_addr);
    reg_rd(CRDMA_OFF_LAST_IDX, 32'h2);
    wait_idle();
    check("msi count", 64'h1, 64'(u_crdma_host_model.n_msi));
    check("msi_req idle", 64'h0, {63'h0, msi_req});
    check("writes", 64'h3, 64'(u_crdma_host_model.wr_q.size()));
    check("count 1", 64'h1_0001, 64'(u_crdma_host_model.wr_q[0]));
    check("count 2", 64'h2, 64'(u_crdma_host_model.wr_q[1]));
    check("count 3", 64'h1_0003, 64'(u_crdma_host_model.wr_q[2]));
    // the host's own poll of the count word in its memory
    check("polled count", 64'h1_0003, 64'(u_crdma_host_model.mem[64'h90c]));
    for (int i = 0; i < 3; i++)
      check("count addr", 64'h90c, u_crdma_host_model.wa_q[i]);
    reg_rd(CRDMA_OFF_STATUS, 32'h3);
    // the later descriptor overwrites the earlier one in words 0 to 643
    for (int k = 0; k < CRDMA_MEM_DEPTH; k++)
      ep_chk(k, k < 644 ? 32'hcccc_0001 + 32'(k) : 32'hbbbb_0001 + 32'(k));
  endtask : t_chain
  // a live and an empty descriptor above 4 GB, slow host, no interrupt asked for
  task automatic t_single();
    u_crdma_host_model.lat = 3;
    // a start strobe while the clock enable is low must be ignored
    @(negedge clk);
    ce = 1'b0;
    reg_wr(CRDMA_OFF_LAST_IDX, 32'h0);
    check("busy frozen", 64'h0, {63'h0, busy});
    ce = 1'b1;
    reg_rd(CRDMA_OFF_LAST_IDX, 32'h2);
    put_desc(64'h1_0000_0a10, 32'h0002_0052, 32'h3, 32'h0, 32'h8df0, 32'haaa0_0001);
    // zero length: no data moves, the count is still written
    put_desc(64'h1_0000_0a20, 32'h0000_0000, 32'h3ff, 32'h0, 32'h8df0, 32'h0);
    reg_wr(CRDMA_OFF_COUNT_CTRL, 32'h2);
    reg_wr(CRDMA_OFF_TAB_HI, 32'h1);
    reg_wr(CRDMA_OFF_TAB_LO, 32'ha00);
    reg_wr(CRDMA_OFF_LAST_IDX, 32'h1);
    wait_idle();
    check("count", 64'h1_0001, 64'(u_crdma_host_model.wr_q[3]));
    check("empty count", 64'h2, 64'(u_crdma_host_model.wr_q[4]));
    check("count addr", 64'h1_0000_0a0c, u_crdma_host_model.wa_q[3]);
    check("count addr", 64'h1_0000_0a0c, u_crdma_host_model.wa_q[4]);
    check("msi count", 64'h1, 64'(u_crdma_host_model.n_msi));
    reg_rd(CRDMA_OFF_STATUS, 32'h2);
    ep_chk(2, 32'hcccc_0003);
    ep_chk(85, 32'hcccc_0056);
    ep_chk(1023, 32'hbbbb_0400);
    for (int k = 0; k < 82; k++)
      ep_chk(3 + k, 32'haaa0_0001 + 32'(k));
  endtask : t_single
  // verdict and end of run
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // reset for 12 cycles, then the scenarios
  initial begin
    repeat (12) @(negedge clk);
    check("busy in reset", 64'h0, {63'h0, busy});
    check("mst_req in reset", 64'h0, {63'h0, mst_req});
    check("msi_req in reset", 64'h0, {63'h0, msi_req});
    check("tgt_rvalid in reset", 64'h0, {63'h0, tgt_rvalid});
    nrst = 1'b1;
    ce = 1'b1;
    t_chain();
    t_single();
    stop_test();
  end
endmodule : testbench
